// *** shared/ppirq_consts.svh ***
// constants for the pin port control and interrupt block
`ifndef PPIRQ_CONSTS_SVH
`define PPIRQ_CONSTS_SVH
`define PPIRQ_PINS 8
`define PPIRQ_OE_LINES 16
`define PPIRQ_DM_RESET 3'h0
`define PPIRQ_BUF_DISABLED_VALUE 1'h0
`endif

// *** shared/ppirq_pkg.sv ***
// types for the pin port control and interrupt block
package ppirq_pkg;
  typedef enum logic [2:0] {
    ppirq_dm_hiz_analog, ppirq_dm_hiz_digital, ppirq_dm_res_up, ppirq_dm_res_down,
    ppirq_dm_od_low, ppirq_dm_od_high, ppirq_dm_strong, ppirq_dm_res_both
  } ppirq_dm_e;
  typedef enum logic [1:0] {
    ppirq_irq_none, ppirq_irq_rise, ppirq_irq_fall, ppirq_irq_both
  } ppirq_irq_e;
  typedef enum logic [1:0] {
    ppirq_vth_half_supply, ppirq_vth_04_supply, ppirq_vth_half_ref, ppirq_vth_full_ref
  } ppirq_vth_e;
endpackage : ppirq_pkg

// *** rtl/ppirq_port.sv ***
// eight-pin port control with edge interrupt unit
`timescale 1ns/10ps
`include "ppirq_consts.svh"
module ppirq_port #(
  parameter int PINS = `PPIRQ_PINS,
  parameter int OE_LINES = `PPIRQ_OE_LINES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [PINS-1:0] wr_port_output_value,
  input wire logic [PINS-1:0] port_output_value_in,
  input wire logic [PINS-1:0] wr_port_cfg,
  input wire logic [3*PINS-1:0] pin_drive_mode_select_in,
  input wire logic [PINS-1:0] pin_slew_select_in,
  input wire logic [PINS-1:0] hw_conn_in,
  input wire logic [PINS-1:0] bidir_en_in,
  input wire logic [4*PINS-1:0] oe_sel_in,
  input wire logic [2*PINS-1:0] irq_mode_in,
  input wire logic [PINS-1:0] in_buf_dis_in,
  input wire logic [PINS-1:0] reg_high_in,
  input wire logic [PINS-1:0] hyst_en_in,
  input wire logic [PINS/2*2-1:0] pair_vth_in,
  input wire logic lvttl_sel_in,
  input wire logic pin_wr,
  input wire logic [2:0] pin_wr_idx,
  input wire logic [7:0] pin_wr_data,
  input wire logic [2:0] pin_rd_idx,
  input wire logic [PINS-1:0] nv_reset_pull_up,
  input wire logic [PINS-1:0] nv_reset_pull_down,
  input wire logic [PINS-1:0] routed_out,
  input wire logic [OE_LINES-1:0] aux_oe_bus,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] status_clr,
  output logic [PINS-1:0] port_output_value,
  output logic [3*PINS-1:0] pin_drive_mode_select,
  output logic [PINS-1:0] pin_slew_select,
  output logic [PINS-1:0] pin_state_value,
  output logic [PINS-1:0] irq_status,
  output logic port_irq_unit_req,
  output logic [7:0] pin_rd_data,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pad_pull_up,
  output logic [PINS-1:0] pad_pull_down,
  output logic [PINS-1:0] pad_in_buf_en,
  output logic [PINS-1:0] pad_slow_slew,
  output logic [PINS-1:0] pad_reg_high,
  output logic [PINS-1:0] pad_hyst_en,
  output logic [PINS/2*2-1:0] pad_pair_vth,
  output logic pad_lvttl
);
  // ----------------------------------------
  // configuration registers and internal signals
  // ----------------------------------------
  logic [PINS-1:0] hw_conn;
  logic [PINS-1:0] bidir_en;
  logic [4*PINS-1:0] oe_sel;
  logic [2*PINS-1:0] irq_mode;
  logic [PINS-1:0] in_buf_dis;
  logic [PINS-1:0] reg_high;
  logic [PINS-1:0] hyst_en;
  logic rst_d;
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] sync3;
  logic [PINS-1:0] in_filt;
  logic [PINS-1:0] in_prev;
  logic [PINS-1:0] prev_load;
  logic [PINS-1:0] edge_hit;
  logic [PINS-1:0] next_status;
  logic [PINS-1:0] next_pad_out;
  logic [PINS-1:0] next_pad_oe;
  logic [PINS-1:0] next_pu;
  logic [PINS-1:0] next_pd;
  logic [PINS-1:0] next_ibuf;
  logic [PINS-1:0] next_slow;
  // ----------------------------------------
  // pin-form read
  // ----------------------------------------
  // pin-form read: dr, slew, ibuf dis, bidir, dm[2:0], state
  wire [7:0] pin_form_rd = {port_output_value[pin_rd_idx], pin_slew_select[pin_rd_idx],
    in_buf_dis[pin_rd_idx], bidir_en[pin_rd_idx],
    pin_drive_mode_select[3*pin_rd_idx +: 3], pin_state_value[pin_rd_idx]};

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // drive mode compare, used by every pin
  function automatic logic mode_is(input logic [2:0] dm, input ppirq_pkg::ppirq_dm_e m);
    mode_is = (dm == 3'(m));
  endfunction : mode_is

  // interrupt mode compare, used by every pin
  function automatic logic irq_is(input logic [1:0] im, input ppirq_pkg::ppirq_irq_e m);
    irq_is = (im == 2'(m));
  endfunction : irq_is

  // ----------------------------------------
  // reset release marker
  // ----------------------------------------
  // low for one edge after release
  always_ff @(posedge core_clk)
  begin
    rst_d <= rstn;
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      wire port_wr = wr_port_cfg[g];
      wire pin_hit = pin_wr && (pin_wr_idx == 3'(g));
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
        begin
          pin_drive_mode_select[3*g +: 3] <= `PPIRQ_DM_RESET;
          port_output_value[g] <= 1'h0;
          pin_slew_select[g] <= 1'h0;
          bidir_en[g] <= 1'h0;
          in_buf_dis[g] <= 1'h0;
          hw_conn[g] <= 1'h0;
          oe_sel[4*g +: 4] <= 4'h0;
          irq_mode[2*g +: 2] <= 2'h0;
          reg_high[g] <= 1'h0;
          hyst_en[g] <= 1'h0;
        end
        else if (!rst_d)
        begin
          if (nv_reset_pull_up[g] && nv_reset_pull_down[g])
            pin_drive_mode_select[3*g +: 3] <= 3'(ppirq_pkg::ppirq_dm_res_both);
          else if (nv_reset_pull_up[g])
          begin
            pin_drive_mode_select[3*g +: 3] <= 3'(ppirq_pkg::ppirq_dm_res_up);
            port_output_value[g] <= 1'h1;
          end
          else if (nv_reset_pull_down[g])
            pin_drive_mode_select[3*g +: 3] <= 3'(ppirq_pkg::ppirq_dm_res_down);
        end
        else if (pin_hit)
        begin
          port_output_value[g] <= pin_wr_data[7];
          pin_slew_select[g] <= pin_wr_data[6];
          in_buf_dis[g] <= pin_wr_data[5];
          bidir_en[g] <= pin_wr_data[4];
          pin_drive_mode_select[3*g +: 3] <= pin_wr_data[3:1];
        end
        else
        begin
          if (wr_port_output_value[g])
            port_output_value[g] <= port_output_value_in[g];
          if (port_wr)
          begin
            pin_drive_mode_select[3*g +: 3] <= pin_drive_mode_select_in[3*g +: 3];
            pin_slew_select[g] <= pin_slew_select_in[g];
            bidir_en[g] <= bidir_en_in[g];
            in_buf_dis[g] <= in_buf_dis_in[g];
            hw_conn[g] <= hw_conn_in[g];
            oe_sel[4*g +: 4] <= oe_sel_in[4*g +: 4];
            irq_mode[2*g +: 2] <= irq_mode_in[2*g +: 2];
            reg_high[g] <= reg_high_in[g];
            hyst_en[g] <= hyst_en_in[g];
          end
        end
      end

      // ----------------------------------------
      // drive decode
      // ----------------------------------------
      // per-pin drive mode field
      wire [2:0] dm = pin_drive_mode_select[3*g +: 3];
      wire dout = hw_conn[g] ? routed_out[g] : port_output_value[g];
      // select one of the oe lines
      wire aux_oe = aux_oe_bus[oe_sel[4*g +: 4]];
      // bidirectional high-Z digital when oe low
      wire bid_off = bidir_en[g] && !aux_oe;
      wire is_strong = mode_is(dm, ppirq_pkg::ppirq_dm_strong);
      wire is_odl = mode_is(dm, ppirq_pkg::ppirq_dm_od_low);
      wire is_odh = mode_is(dm, ppirq_pkg::ppirq_dm_od_high);
      wire is_rup = mode_is(dm, ppirq_pkg::ppirq_dm_res_up);
      wire is_rdn = mode_is(dm, ppirq_pkg::ppirq_dm_res_down);
      wire is_rboth = mode_is(dm, ppirq_pkg::ppirq_dm_res_both);
      wire res_ok = !reg_high[g];
      wire drv = !bid_off && (is_strong || (is_odl && !dout) || (is_odh && dout) ||
        (is_rup && !dout) || (is_rdn && dout));
      wire pu = !bid_off && res_ok && ((is_rup || is_rboth) && dout);
      wire pd = !bid_off && res_ok && ((is_rdn || is_rboth) && !dout);
      // slew only strong or open drain
      wire slow = pin_slew_select[g] && (is_strong || is_odl || is_odh);
      wire ibuf = !mode_is(dm, ppirq_pkg::ppirq_dm_hiz_analog) && !in_buf_dis[g];
      assign next_pad_out[g] = dout;
      assign next_pad_oe[g] = drv;
      assign next_pu[g] = pu;
      assign next_pd[g] = pd;
      assign next_ibuf[g] = ibuf;
      assign next_slow[g] = slow;
      assign in_filt[g] = ibuf ? sync3[g] : `PPIRQ_BUF_DISABLED_VALUE;

      // ----------------------------------------
      // edge detect
      // ----------------------------------------
      wire [1:0] im = irq_mode[2*g +: 2];
      wire rise = in_filt[g] && !in_prev[g];
      wire fall = !in_filt[g] && in_prev[g];
      wire want_rise = irq_is(im, ppirq_pkg::ppirq_irq_rise) ||
        irq_is(im, ppirq_pkg::ppirq_irq_both);
      wire want_fall = irq_is(im, ppirq_pkg::ppirq_irq_fall) ||
        irq_is(im, ppirq_pkg::ppirq_irq_both);
      // change counts once stages two and three agree
      wire settled = (sync2[g] == sync3[g]);
      // previous level follows only settled or disabled inputs
      assign prev_load[g] = !ibuf || settled;
      assign edge_hit[g] = ibuf && settled && ((want_rise && rise) || (want_fall && fall));
    end
  endgenerate

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  // write one clears
  wire [PINS-1:0] status_kept = irq_status & ~status_clr;
  assign next_status = status_kept | edge_hit;

  // ----------------------------------------
  // synchroniser, status and pad registers
  // ----------------------------------------
  // runs on core_clk like the configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      in_prev <= '0;
      irq_status <= '0;
      port_irq_unit_req <= 1'h0;
      pin_state_value <= '0;
      pin_rd_data <= 8'h00;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      // previous level held per pin while it settles
      in_prev <= (in_prev & ~prev_load) | (in_filt & prev_load);
      irq_status <= next_status;
      port_irq_unit_req <= |next_status;
      pin_state_value <= in_filt;
      pin_rd_data <= pin_form_rd;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      pad_pull_up <= '0;
      pad_pull_down <= '0;
      pad_in_buf_en <= '0;
      pad_slow_slew <= '0;
      pad_reg_high <= '0;
      pad_hyst_en <= '0;
      pad_pair_vth <= '0;
      pad_lvttl <= 1'h0;
    end
    else
    begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
      pad_pull_up <= next_pu;
      pad_pull_down <= next_pd;
      pad_in_buf_en <= next_ibuf;
      pad_slow_slew <= next_slow;
      pad_reg_high <= reg_high;
      pad_hyst_en <= hyst_en;
      pad_pair_vth <= pair_vth_in;
      pad_lvttl <= lvttl_sel_in;
    end
  end
endmodule : ppirq_port

// *** bench/ppirq_pins_model.sv ***
// board circuitry seen by the eight port pins
`timescale 1ns/10ps
module ppirq_pins_model (
  input wire logic core_clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pull_up,
  input wire logic [7:0] pad_pull_down,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] flt = 8'h55;
  // undriven lines without a pull wander every cycle
  always @(posedge core_clk) flt <= ~flt;
  // pad drive first, then board, then pulls
  assign pin_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pull_up | (~pad_pull_down & flt)));
endmodule : ppirq_pins_model

// *** bench/ppirq_port_sva.sv ***
// port-level assertions for the port block
`timescale 1ns/10ps
module ppirq_port_sva #(
  parameter int PINS = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [PINS-1:0] nv_reset_pull_up,
  input wire logic [PINS-1:0] nv_reset_pull_down,
  input wire logic [PINS-1:0] status_clr,
  input wire logic lvttl_sel_in,
  input wire logic [3*PINS-1:0] pin_drive_mode_select,
  input wire logic [PINS-1:0] irq_status,
  input wire logic port_irq_unit_req,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] pad_pull_up,
  input wire logic [PINS-1:0] pad_pull_down,
  input wire logic [PINS-1:0] pad_slow_slew,
  input wire logic [PINS-1:0] pad_reg_high,
  input wire logic pad_lvttl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence held_bit;
    irq_status[0] && !status_clr[0];
  endsequence
  sequence steady_run;
    rstn ##1 rstn;
  endsequence
  reset_hiz_a: assert property (disable iff (1'b0) !rstn |=> pin_drive_mode_select == '0 && pad_oe == '0) else $error("pin not high-Z analog in reset");
  nv_load_a: assert property ($rose(rstn) |=> pin_drive_mode_select[2:0] == {$past(nv_reset_pull_up[0]) & $past(nv_reset_pull_down[0]), $past(nv_reset_pull_up[0]) | $past(nv_reset_pull_down[0]), $past(nv_reset_pull_down[0])}) else $error("reset config not loaded");
  req_or_a: assert property (port_irq_unit_req == |irq_status) else $error("request differs from status");
  status_hold_a: assert property (held_bit |=> irq_status[0]) else $error("status bit lost");
  oe_mode_a: assert property (pad_oe[3] |-> $past(pin_drive_mode_select[11:10]) != 2'h0) else $error("drive in high-Z mode");
  slew_mask_a: assert property (pad_slow_slew[4] |-> $past(pin_drive_mode_select[14]) && $past(pin_drive_mode_select[14:12]) != 3'h7) else $error("slew in resistive mode");
  lvttl_pass_a: assert property (steady_run |=> pad_lvttl == $past(lvttl_sel_in)) else $error("threshold select not passed");
  reghigh_pull_a: assert property (!(|(pad_reg_high & (pad_pull_up | pad_pull_down)))) else $error("pull with regulated high");
endmodule : ppirq_port_sva
bind ppirq_port ppirq_port_sva #(.PINS(PINS)) i_ppirq_port_sva (.core_clk(core_clk), .rstn(rstn),
  .nv_reset_pull_up(nv_reset_pull_up), .nv_reset_pull_down(nv_reset_pull_down),
  .status_clr(status_clr), .lvttl_sel_in(lvttl_sel_in),
  .pin_drive_mode_select(pin_drive_mode_select), .irq_status(irq_status),
  .port_irq_unit_req(port_irq_unit_req), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
  .pad_pull_down(pad_pull_down), .pad_slow_slew(pad_slow_slew), .pad_reg_high(pad_reg_high),
  .pad_lvttl(pad_lvttl));

// *** bench/ppirq_port_tb.sv ***
// self-checking bench for the port block
`timescale 1ns/10ps
module ppirq_port_tb;
  logic core_clk = 1'b0, rstn = 1'b0, lvttl = 1'b0, pin_wr = 1'b0, req;
  logic [7:0] wr_dr = '0, dr_in = '0, wr_cfg = '0, slew = '0, hw = '0, bidir = '0, ibd = '0;
  logic [7:0] reg_hi = '0, hyst = '0, vth = '0, rout = '0, sclr = '0, ev = '0;
  logic [7:0] pov, sls, psv, ist, rdd, pad_out, pad_oe, pu, pd, pin_in, wdat = '0;
  logic [7:0] ibe, slw, rh, hy, vt;
  logic lvt;
  logic [2:0] widx = '0, ridx = '0;
  logic [15:0] irq_in = '0, aux = '0;
  logic [23:0] dms_in = '0, dms;
  logic [31:0] oesel = '0;
  logic [4:0] rows [7] = '{5'b01011, 5'b01100, 5'b10101, 5'b10010, 5'b11011, 5'b11101, 5'b00010};
  int failures = 0, compares = 0, cyc = 0;
  ppirq_port i_ppirq_port (.core_clk(core_clk), .rstn(rstn), .wr_port_output_value(wr_dr),
    .port_output_value_in(dr_in), .wr_port_cfg(wr_cfg), .pin_drive_mode_select_in(dms_in),
    .pin_slew_select_in(slew), .hw_conn_in(hw), .bidir_en_in(bidir), .oe_sel_in(oesel),
    .irq_mode_in(irq_in), .in_buf_dis_in(ibd), .reg_high_in(reg_hi), .hyst_en_in(hyst),
    .pair_vth_in(vth), .lvttl_sel_in(lvttl), .pin_wr(pin_wr), .pin_wr_idx(widx),
    .pin_wr_data(wdat), .pin_rd_idx(ridx), .nv_reset_pull_up(8'h01),
    .nv_reset_pull_down(8'h02), .routed_out(rout), .aux_oe_bus(aux), .pin_in(pin_in),
    .status_clr(sclr), .port_output_value(pov), .pin_drive_mode_select(dms),
    .pin_slew_select(sls), .pin_state_value(psv), .irq_status(ist), .port_irq_unit_req(req),
    .pin_rd_data(rdd), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu),
    .pad_pull_down(pd), .pad_in_buf_en(ibe), .pad_slow_slew(slw), .pad_reg_high(rh),
    .pad_hyst_en(hy), .pad_pair_vth(vt), .pad_lvttl(lvt));
  ppirq_pins_model i_ppirq_pins_model (.core_clk(core_clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pu), .pad_pull_down(pd), .ext_en(8'h01), .ext_val(ev),
    .pin_in(pin_in));
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(negedge core_clk);
  endtask : ticks
  task automatic cfg(input int p, input logic [2:0] dm, input logic [1:0] im, input logic ib);
    ticks(1);
    dms_in[p*3 +: 3] = dm;
    irq_in[p*2 +: 2] = im;
    ibd[p] = ib;
    wr_cfg[p] = 1'b1;
    ticks(1);
    wr_cfg[p] = 1'b0;
  endtask : cfg
  task automatic clr;
    ticks(1);
    sclr = 8'hff;
    ticks(1);
    sclr = 8'h00;
  endtask : clr
  task automatic close_out;
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    ticks(20);
    chk(dms | {pu, pd, pad_oe}, 24'h0);
    rstn = 1'b1;
    ticks(2);
    chk({pov, dms[15:0]}, 24'h01001a);
    foreach (rows[k])
    begin
      ev[0] = rows[k][2];
      cfg(0, 3'h1, rows[k][4:3], 1'b0);
      ticks(6);
      clr();
      ev[0] = rows[k][1];
      ticks(6);
      chk({ist[0], req}, {2{rows[k][0]}});
    end
    cfg(0, 3'h1, 2'h3, 1'b1);
    clr();
    ev[0] = 1'b0;
    ticks(6);
    ev[0] = 1'b1;
    ticks(6);
    chk({ist[0], psv[0]}, 2'b00);
    pin_wr = 1'b1;
    widx = 3'h3;
    ridx = 3'h3;
    wdat = 8'hcc;
    ticks(1);
    pin_wr = 1'b0;
    ticks(1);
    chk({pov[3], sls[3], dms[14:6], rdd[7:1], pad_oe[3], pad_out[3]}, 20'hc619b);
    bidir[1] = 1'b1;
    oesel[7:4] = 4'h5;
    aux = 16'h0010;
    cfg(1, 3'h6, 2'h0, 1'b0);
    ticks(3);
    chk(pad_oe[1], 1'b0);
    aux = 16'h0020;
    ticks(3);
    chk(pad_oe[1], 1'b1);
    dms_in[23:12] = 12'hdb6;
    {reg_hi, hyst, hw, rout, slew, vth} = {8'h30, 8'hc0, 8'h40, 8'h40, 8'h10, 8'h1b};
    {wr_dr, dr_in, lvttl, wr_cfg} = {8'h80, 8'h80, 1'b1, 8'hf0};
    ticks(1);
    {wr_dr, wr_cfg} = 16'h0;
    ticks(2);
    chk({pov[7:6], pad_out[7:6], dms[23:12]}, {4'b1011, 12'hdb6});
    chk({ibe, slw, hy}, {8'hfa, 8'h18, 8'hc0});
    chk({rh, vt, lvt}, {8'h30, 8'h1b, 1'b1});
    {pin_wr, widx, wdat} = {1'b1, 3'h5, 8'h84};
    ticks(1);
    widx = 3'h2;
    ticks(1);
    pin_wr = 1'b0;
    ticks(2);
    chk({pu[5], pu[2], pad_oe[5], pad_oe[2]}, 4'b0100);
    rstn = 1'b0;
    ticks(2);
    chk(dms | {pu, pd, pad_oe}, 24'h0);
    rstn = 1'b1;
    ticks(2);
    chk({pov, dms[15:0]}, 24'h01001a);
    close_out();
  end
endmodule : ppirq_port_tb
